// ---- test_zero_extend_byte_unit.sv ----
// testbench: zero-extension unit against a register-array model
module test_zero_extend_byte_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0;
  logic rst_n = 0;
  logic instr_valid = 0;
  logic mem_rd_ack = 0;
  logic [23:0] instr_word = '0;
  logic [7:0] mem_rd_byte = '0;
  logic [3:0] dbg_reg_idx = '0;
  logic instr_ready, instr_done, instr_illegal, mem_rd_req;
  logic [15:0] mem_rd_addr, dbg_reg_data, status_word, sr_e;
  logic [15:0] w [16];
  int failures = 0;
  int compares = 0;
  int seed = 10758;

  always #2.5 sys_clk = ~sys_clk;

  zxb_unit zxb_unit_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .instr_done(instr_done),
    .instr_illegal(instr_illegal), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack),
    .mem_rd_byte(mem_rd_byte), .dbg_reg_idx(dbg_reg_idx),
    .dbg_reg_data(dbg_reg_data), .status_word(status_word));

  // ****************************************
  // checking and stimulus tasks
  // ****************************************
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task tally_and_finish;
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // debug port lags one cycle, so wait two edges
  task peek(input logic [3:0] r, input string n);
    @(posedge sys_clk) dbg_reg_idx <= r;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) chk(n, w[r], dbg_reg_data);
  endtask

  task op(input logic [12:0] p, input logic [2:0] m, input logic [3:0] d,
          input logic [3:0] s, input logic [7:0] b, input int lat);
    logic [15:0] a;
    logic [7:0] v;
    logic bad;
    bad = (m > 5) || (p != 13'h1F70);
    a = (m == 4) ? w[s] + 1 : (m == 5) ? w[s] - 1 : w[s];
    v = (m == 0) ? w[s][7:0] : b;
    @(posedge sys_clk) begin
      instr_valid <= 1;
      instr_word <= {p, d, m, s};
    end
    @(negedge sys_clk) chk("ready", 1, instr_ready);
    chk("illegal", bad, instr_illegal);
    if (m == 0 && !bad) chk("done", 1, instr_done);
    if (bad) chk("done", 0, instr_done);
    @(posedge sys_clk) begin
      instr_valid <= 0;
      instr_word <= 24'($random(seed));
    end
    if (m != 0 && !bad) begin
      @(negedge sys_clk) chk("addr", a, mem_rd_addr);
      chk("req", 1, mem_rd_req);
      repeat (lat) @(posedge sys_clk);
      @(posedge sys_clk) begin
        mem_rd_ack <= 1;
        mem_rd_byte <= b;
      end
      @(negedge sys_clk) chk("done", 1, instr_done);
      @(posedge sys_clk) begin
        mem_rd_ack <= 0;
        mem_rd_byte <= ~b;
      end
    end
    if (!bad) begin
      if (m > 1) w[s] = (m == 2 || m == 4) ? w[s] + 1 : w[s] - 1;
      w[d] = {8'h00, v};
      sr_e = (v == 0) ? 16'h0003 : 16'h0001;
    end
    peek(d, "dst");
    peek(s, "src");
    chk("status", sr_e, status_word);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1;
    for (int r = 0; r < 16; r++) w[r] = '0;
    sr_e = '0;
    @(negedge sys_clk) chk("status_rst", 0, status_word);
    // zero bytes every seventh op keep the zero flag exercised
    for (int i = 0; i < 60; i++) begin
      op(13'h1F70, 3'($unsigned($random(seed)) % 6), 4'($random(seed)),
         4'($random(seed)), (i % 7 == 0) ? 8'h00 : 8'($random(seed)),
         $unsigned($random(seed)) % 4);
    end
    for (int i = 0; i < 3; i++) begin
      op((i == 2) ? 13'h1F71 : 13'h1F70, (i == 2) ? 3'h0 : 3'(6 + i),
         4'h1, 4'h2, 8'h55, 0);
    end
    tally_and_finish;
  end

  initial begin
    #50000;
    failures++;
    tally_and_finish;
  end
endmodule // test_zero_extend_byte_unit

// ---- zxb_pkg.sv ----
// package: constants and types for the byte zero-extension unit
package zxb_pkg;

  // ****************************************
  // instruction encoding
  // ****************************************
  localparam int ZXB_IW = 24;
  localparam logic [12:0] ZXB_PREFIX = 13'h1F70;
  localparam int ZXB_PFX_HI = 23;
  localparam int ZXB_PFX_LO = 11;
  localparam int ZXB_DST_HI = 10;
  localparam int ZXB_DST_LO = 7;
  localparam int ZXB_MODE_HI = 6;
  localparam int ZXB_MODE_LO = 4;
  localparam int ZXB_SRC_HI = 3;
  localparam int ZXB_SRC_LO = 0;

  // ****************************************
  // status word bit positions
  // ****************************************
  localparam int ZXB_SR_W = 16;
  localparam int ZXB_C_BIT = 0;
  localparam int ZXB_Z_BIT = 1;
  localparam int ZXB_N_BIT = 3;

  localparam logic [15:0] ZXB_PTR_STEP = 16'h0001;
  localparam logic [7:0] ZXB_UPPER_ZERO = 8'h00;

  // source addressing modes
  typedef enum logic [2:0] {
    ZXB_M_DIRECT = 3'h0,
    ZXB_M_IND = 3'h1,
    ZXB_M_IND_POSTINC = 3'h2,
    ZXB_M_IND_POSTDEC = 3'h3,
    ZXB_M_IND_PREINC = 3'h4,
    ZXB_M_IND_PREDEC = 3'h5
  } zxb_mode_t;

endpackage

// ---- zxb_regfile.sv ----
// working register file: sixteen 16-bit registers, two read and two write ports
module zxb_regfile
  import zxb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] rd_a_idx,
  output logic [15:0] rd_a_data,
  input wire logic [3:0] rd_b_idx,
  output logic [15:0] rd_b_data,
  input wire logic we_a,
  input wire logic [3:0] wr_a_idx,
  input wire logic [15:0] wr_a_data,
  input wire logic we_b,
  input wire logic [3:0] wr_b_idx,
  input wire logic [15:0] wr_b_data
);
  logic [15:0] regs_q [16];

  assign rd_a_data = regs_q[rd_a_idx];
  assign rd_b_data = regs_q[rd_b_idx];

  // port a (result) wins when both target one register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= 16'h0000;
      end
    end else begin
      if (we_b) begin
        regs_q[wr_b_idx] <= wr_b_data;
      end
      if (we_a) begin
        regs_q[wr_a_idx] <= wr_a_data;
      end
    end
  end
endmodule // zxb_regfile

// ---- zxb_unit.sv ----
// byte zero-extension execution unit with register file and status word
// Summary of operation
// (RQ1) result is source low byte, upper byte forced to zero
// (RQ2) negative flag cleared and carry flag set every time
// (RQ3) decode prefix 1111 1011 1000 0, then dst, mode, src fields
// (RQ4) source direct or indirect with pre/post inc/dec; destination direct
// (RQ5) indirect update changes source pointer by exactly one
// (RQ6) no size bit; always byte source, word destination
// (RQ7) one word, one cycle; data memory reads may stall
// (RQ8) zero flag set when result is zero, cleared otherwise
module zxb_unit
  import zxb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [23:0] instr_word,
  output logic instr_ready,
  output logic instr_done,
  output logic instr_illegal,
  output logic mem_rd_req,
  output logic [15:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [7:0] mem_rd_byte,
  input wire logic [3:0] dbg_reg_idx,
  output logic [15:0] dbg_reg_data,
  output logic [15:0] status_word
);

  // ****************************************
  // decode
  // ****************************************
  // the word may change once taken, so the wait state decodes a copy
  logic [ZXB_IW-1:0] held_q;
  typedef enum logic {ZXB_IDLE, ZXB_WAIT} zxb_state_t;
  zxb_state_t state_q, state_d;
  wire [ZXB_IW-1:0] instr_cur = (state_q == ZXB_WAIT) ? held_q : instr_word;
  wire is_op = instr_cur[ZXB_PFX_HI:ZXB_PFX_LO] == ZXB_PREFIX; // RQ3 RQ6
  wire [3:0] dst_idx = instr_cur[ZXB_DST_HI:ZXB_DST_LO]; // RQ3
  wire [2:0] mode_f = instr_cur[ZXB_MODE_HI:ZXB_MODE_LO]; // RQ3
  wire [3:0] src_idx = instr_cur[ZXB_SRC_HI:ZXB_SRC_LO]; // RQ3
  wire mode_ok = mode_f <= ZXB_M_IND_PREDEC;
  wire is_direct = mode_f == ZXB_M_DIRECT;
  wire is_pre = mode_f == ZXB_M_IND_PREINC || mode_f == ZXB_M_IND_PREDEC;
  wire is_inc = mode_f == ZXB_M_IND_POSTINC || mode_f == ZXB_M_IND_PREINC;
  wire is_dec = mode_f == ZXB_M_IND_POSTDEC || mode_f == ZXB_M_IND_PREDEC;
  wire legal = is_op && mode_ok;

  // ****************************************
  // operand path
  // ****************************************
  logic [15:0] src_val;
  logic [15:0] dbg_word;
  logic [15:0] sr_q, sr_d;

  wire [15:0] ptr_plus = src_val + ZXB_PTR_STEP; // RQ5
  wire [15:0] ptr_minus = src_val - ZXB_PTR_STEP; // RQ5
  wire [15:0] ptr_new = is_inc ? ptr_plus : (is_dec ? ptr_minus : src_val);
  wire [15:0] ea = is_pre ? ptr_new : src_val; // RQ4

  // direct source finishes at once; indirect waits for the byte (RQ7)
  wire start = instr_valid && state_q == ZXB_IDLE && legal;
  wire direct_done = start && is_direct; // RQ7
  wire ind_done = state_q == ZXB_WAIT && mem_rd_ack;
  wire [7:0] src_byte = is_direct ? src_val[7:0] : mem_rd_byte;
  wire [15:0] result = {ZXB_UPPER_ZERO, src_byte}; // RQ1 RQ4
  wire res_we = direct_done || ind_done;
  wire ptr_we = ind_done && (is_inc || is_dec); // RQ5

  // ****************************************
  // register file
  // ****************************************
  // debug reads use their own port so they never disturb the operand read
  zxb_regfile u_regs (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .rd_a_idx(src_idx),
    .rd_a_data(src_val),
    .rd_b_idx(dbg_reg_idx),
    .rd_b_data(dbg_word),
    .we_a(res_we),
    .wr_a_idx(dst_idx),
    .wr_a_data(result),
    .we_b(ptr_we),
    .wr_b_idx(src_idx),
    .wr_b_data(ptr_new)
  );

  // ready drops while a byte is awaited; the word is latched on take
  assign instr_ready = state_q == ZXB_IDLE;
  assign instr_illegal = instr_valid && instr_ready && !legal;
  assign mem_rd_req = state_q == ZXB_WAIT;
  assign mem_rd_addr = ea;
  assign instr_done = res_we;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ZXB_IDLE: begin
        if (start && !is_direct) begin
          state_d = ZXB_WAIT;
        end
      end
      ZXB_WAIT: begin
        if (mem_rd_ack) begin
          state_d = ZXB_IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // status word
  // ****************************************
  always_comb begin
    sr_d = sr_q;
    if (res_we) begin
      sr_d[ZXB_N_BIT] = 1'b0; // RQ2
      sr_d[ZXB_C_BIT] = 1'b1; // RQ2
      sr_d[ZXB_Z_BIT] = result == 16'h0000; // RQ8
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ZXB_IDLE;
      sr_q <= 16'h0000;
      held_q <= 24'h000000;
    end else begin
      state_q <= state_d;
      sr_q <= sr_d;
      if (start) begin
        held_q <= instr_word;
      end
    end
  end

  assign status_word = sr_q;
  logic [15:0] dbg_q;
  assign dbg_reg_data = dbg_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dbg_q <= 16'h0000;
    end else begin
      dbg_q <= dbg_word;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_upper_zero: assert property ( // RQ1
    res_we |=> u_regs.regs_q[$past(dst_idx)][15:8] == ZXB_UPPER_ZERO)
    else $error("upper byte not cleared");
  a_low_copy: assert property ( // RQ1
    direct_done |=> u_regs.regs_q[$past(dst_idx)][7:0] == $past(src_val[7:0]))
    else $error("low byte not copied");
  a_low_ind: assert property ( // RQ1
    ind_done |=> u_regs.regs_q[$past(dst_idx)][7:0] == $past(mem_rd_byte))
    else $error("fetched byte not copied");
  a_flags_nc: assert property ( // RQ2
    res_we |=> !status_word[ZXB_N_BIT] && status_word[ZXB_C_BIT])
    else $error("n or c flag wrong");
  a_zero_flag: assert property ( // RQ8
    res_we |=> status_word[ZXB_Z_BIT] == ($past(src_byte) == 8'h00))
    else $error("zero flag wrong");
  a_decode_only: assert property ( // RQ3
    instr_done && state_q == ZXB_IDLE |-> is_op)
    else $error("done without opcode");
  a_illegal_quiet: assert property ( // RQ3
    instr_illegal |-> !instr_done)
    else $error("refused word completed");
  a_illegal_keep: assert property ( // RQ3
    instr_illegal |=> $stable(status_word) && !mem_rd_req)
    else $error("refused word changed state");
  a_mode_refuse: assert property ( // RQ4
    instr_valid && instr_ready && mode_f > ZXB_M_IND_PREDEC |-> instr_illegal)
    else $error("reserved mode not refused");
  a_direct_cycle: assert property ( // RQ7
    start && is_direct |-> instr_done ##1 instr_ready)
    else $error("direct not single cycle");
  a_wait_blocks: assert property ( // RQ7
    mem_rd_req |-> !instr_ready)
    else $error("ready while waiting for byte");
  a_req_holds: assert property ( // RQ7
    mem_rd_req && !mem_rd_ack |=> mem_rd_req)
    else $error("byte request dropped early");
  a_ind_release: assert property ( // RQ7
    mem_rd_req && mem_rd_ack |-> instr_done ##1 instr_ready)
    else $error("indirect did not finish on ack");
  a_ptr_step: assert property ( // RQ5
    ptr_we && is_inc && dst_idx != src_idx |=>
      u_regs.regs_q[$past(src_idx)] == $past(src_val) + ZXB_PTR_STEP)
    else $error("pointer step not one");
  a_ptr_dec: assert property ( // RQ5
    ptr_we && is_dec && dst_idx != src_idx |=>
      u_regs.regs_q[$past(src_idx)] == $past(src_val) - ZXB_PTR_STEP)
    else $error("pointer decrement not one");
  a_ptr_plain: assert property ( // RQ5
    ind_done && mode_f == ZXB_M_IND && dst_idx != src_idx |=>
      u_regs.regs_q[$past(src_idx)] == $past(src_val))
    else $error("plain indirect moved pointer");
  a_addr_post: assert property ( // RQ4
    mem_rd_req && !is_pre |-> mem_rd_addr == src_val)
    else $error("post or plain address wrong");
  a_addr_preinc: assert property ( // RQ5
    mem_rd_req && mode_f == ZXB_M_IND_PREINC |->
      mem_rd_addr == src_val + ZXB_PTR_STEP)
    else $error("pre-increment address wrong");
  a_addr_predec: assert property ( // RQ5
    mem_rd_req && mode_f == ZXB_M_IND_PREDEC |->
      mem_rd_addr == src_val - ZXB_PTR_STEP)
    else $error("pre-decrement address wrong");
  a_addr_steady: assert property ( // RQ4
    mem_rd_req && !mem_rd_ack |=> $stable(mem_rd_addr))
    else $error("address moved while waiting");
  a_ptr_indirect: assert property ( // RQ4
    ptr_we |-> !is_direct)
    else $error("pointer update in direct mode");
  a_no_mem_direct: assert property ( // RQ4
    start && is_direct |=> !mem_rd_req)
    else $error("memory read on direct");

endmodule // zxb_unit
